//--- hdl/ffr_core.v
/*
 Flash fetch fault recovery: machine check / checkstop choice, syndrome,
 vector formation and keyed run-mode changes that cycle the flash.
 Assumes APB master on pclk, flash and wakeup signals from the same clock.
*/
`timescale 1ns/1ps
`include "ffr_defs.vh"
module ffr_core #(
    parameter HAS_CHECKSTOP  = 1,
    parameter HAS_VEC_REGS   = 0,
    parameter EXIT_CYCLES    = `FFR_EXIT_CYCLES
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Core fetch and power events
    input  wire        fetch_req,
    input  wire        lp_entry,
    input  wire        wakeup,
    input  wire        irq_req,
    input  wire [3:0]  irq_type,
    // Core outcome
    output reg         fetch_read_bus_error,
    output reg         checkstop_reset,
    output reg         mc_taken,
    output reg         irq_taken,
    output reg  [31:0] handler_addr,
    output reg         flash_usable
);
    localparam ST_NORMAL = 2'd0;
    localparam ST_LOW    = 2'd1;
    localparam ST_EXIT   = 2'd2;

    localparam MS_IDLE   = 1'b0;
    localparam MS_KEYED  = 1'b1;

    reg  [31:0] machine_state_reg;
    reg  [31:0] mc_syndrome_reg;
    reg  [31:0] vector_prefix_reg;
    reg  [31:0] run0_cfg;
    reg  [15:0] mode_target;
    reg         mode_seq;
    reg         mode_transition_flag;
    reg  [1:0]  flash_state;
    reg  [1:0]  low_power_state;
    reg         flash_sync_ok;
    reg  [1:0]  fl_req;
    reg  [31:0] exit_cnt;
    reg         pend_vec;
    reg         pend_mc;
    reg  [3:0]  pend_type;
    reg  [11:0] fixed_off;

    wire        apb_wr = psel & penable & pwrite;
    wire        apb_rd = psel & penable & ~pwrite;
    wire        me_bit = machine_state_reg[`FFR_MSR_ME_BIT];
    wire [11:0] vec_rdata;
    wire        vec_wr = apb_wr & (paddr[11:6] == 6'h01);
    wire [1:0]  run0_flash = run0_cfg[`FFR_FLASH_LSB+1:`FFR_FLASH_LSB];
    wire        fault = fetch_req & ~flash_usable;
    // Look up the coming type so registered data meets the address stage
    wire [3:0]  next_vec_type = fault ? 4'h1 : (irq_req ? irq_type : pend_type);

    function [31:0] ffr_form_addr;
        input [31:0] prefix;
        input [11:0] off;
        begin
            ffr_form_addr = {prefix[31:12], off};
        end
    endfunction

    ffr_vec_mem #(
        .DEPTH (16),
        .AW    (4)
    ) u_vec (
        .pclk    (pclk),
        .wr_en   (vec_wr),
        .wr_addr (paddr[5:2]),
        .wr_data (pwdata[11:0]),
        .rd_addr (next_vec_type),
        .rd_data (vec_rdata)
    );

    // Hard-wired offsets, sixteen bytes per type
    always @* begin
        fixed_off = {4'h0, pend_type, 4'h0};
    end

    // APB read mux; unmapped reads return zero with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel & ~penable) begin
                if (paddr == `FFR_OFF_MSR) begin
                    prdata <= machine_state_reg;
                end else if (paddr == `FFR_OFF_SYNDROME) begin
                    prdata <= mc_syndrome_reg;
                end else if (paddr == `FFR_OFF_PREFIX) begin
                    prdata <= vector_prefix_reg;
                end else if (paddr == `FFR_OFF_MODE_CTL) begin
                    prdata <= {mode_target, 16'h0000};
                end else if (paddr == `FFR_OFF_RUN0_CFG) begin
                    prdata <= run0_cfg;
                end else if (paddr == `FFR_OFF_STATUS) begin
                    prdata <= {27'h0, flash_sync_ok, flash_state, mode_seq, mode_transition_flag};
                end else if (paddr == `FFR_OFF_LP_CFG) begin
                    prdata <= {30'h0, low_power_state};
                end else if (paddr == `FFR_OFF_HANDLER) begin
                    prdata <= handler_addr;
                end else if (paddr[11:6] == 6'h01) begin
                    prdata <= 32'h0000_0000;
                end else begin
                    pslverr <= ~pwrite;
                    if (pwrite) begin
                        pslverr <= 1'b1;
                    end
                end
            end
        end
    end

    // Software registers, machine check side effects and syndrome
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_state_reg <= `FFR_MSR_RESET;
            mc_syndrome_reg   <= 32'h0000_0000;
            vector_prefix_reg <= 32'h0000_0000;
            run0_cfg          <= `FFR_RUN0_RESET;
            low_power_state   <= `FFR_FLASH_PD;
        end else begin
            if (apb_wr && paddr == `FFR_OFF_MSR) begin
                machine_state_reg <= pwdata;
            end
            if (apb_wr && paddr == `FFR_OFF_SYNDROME) begin
                mc_syndrome_reg <= mc_syndrome_reg & ~pwdata;
            end
            if (apb_wr && paddr == `FFR_OFF_PREFIX) begin
                vector_prefix_reg <= pwdata;
            end
            if (apb_wr && paddr == `FFR_OFF_RUN0_CFG) begin
                run0_cfg <= pwdata;
            end
            if (apb_wr && paddr == `FFR_OFF_LP_CFG) begin
                low_power_state <= pwdata[1:0];
            end
            // Hardware set wins over a same-cycle software write
            if (fault && (HAS_CHECKSTOP == 0 || me_bit)) begin
                mc_syndrome_reg <= mc_syndrome_reg | `FFR_SYN_FETCH_ERR;
                machine_state_reg[`FFR_MSR_EE_BIT] <= 1'b0;
                machine_state_reg[`FFR_MSR_ME_BIT] <= 1'b0;
            end
        end
    end

    // Fault outcome: checkstop or machine check
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_read_bus_error <= 1'b0;
            checkstop_reset      <= 1'b0;
            pend_mc              <= 1'b0;
            pend_vec             <= 1'b0;
            pend_type            <= 4'h0;
        end else begin
            fetch_read_bus_error <= fault;
            checkstop_reset      <= 1'b0;
            pend_vec             <= 1'b0;
            pend_mc              <= 1'b0;
            if (fault) begin
                if (HAS_CHECKSTOP != 0 && !me_bit) begin
                    checkstop_reset <= 1'b1;
                end else begin
                    pend_vec  <= 1'b1;
                    pend_mc   <= 1'b1;
                    pend_type <= 4'h1;
                end
            end else if (irq_req) begin
                pend_vec  <= 1'b1;
                pend_type <= irq_type;
            end
        end
    end

    // Handler address formed one cycle after vector lookup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            handler_addr <= 32'h0000_0000;
            mc_taken     <= 1'b0;
            irq_taken    <= 1'b0;
        end else begin
            mc_taken  <= pend_vec & pend_mc;
            irq_taken <= pend_vec & ~pend_mc;
            if (pend_vec) begin
                if (HAS_VEC_REGS != 0) begin
                    handler_addr <= ffr_form_addr(vector_prefix_reg, vec_rdata);
                end else if (pend_mc) begin
                    handler_addr <= ffr_form_addr(vector_prefix_reg, `FFR_MC_OFFSET);
                end else begin
                    handler_addr <= ffr_form_addr(vector_prefix_reg, fixed_off);
                end
            end
        end
    end

    // Keyed mode control sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_seq    <= MS_IDLE;
            mode_target <= 16'h0000;
            fl_req      <= 2'b00;
        end else begin
            fl_req <= 2'b00;
            if (apb_wr && paddr == `FFR_OFF_MODE_CTL) begin
                case (mode_seq)
                    MS_IDLE: begin
                        if (pwdata[15:0] == `FFR_KEY) begin
                            mode_seq    <= MS_KEYED;
                            mode_target <= pwdata[31:16];
                        end
                    end
                    default: begin
                        mode_seq <= MS_IDLE;
                        if (pwdata[15:0] == `FFR_KEY_INV && pwdata[31:16] == mode_target) begin
                            fl_req <= run0_flash;
                        end
                    end
                endcase
            end
        end
    end

    // Flash power state and transition flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_state          <= ST_NORMAL;
            flash_sync_ok        <= 1'b1;
            flash_usable         <= 1'b1;
            mode_transition_flag <= 1'b0;
            exit_cnt             <= 32'h0000_0000;
        end else begin
            case (flash_state)
                ST_NORMAL: begin
                    if (lp_entry && !wakeup) begin
                        flash_state   <= ST_LOW;
                        flash_sync_ok <= 1'b0;
                        flash_usable  <= 1'b0;
                    end else if (fl_req == `FFR_FLASH_PD || fl_req == `FFR_FLASH_LP) begin
                        flash_state   <= ST_LOW;
                        flash_sync_ok <= 1'b1;
                        flash_usable  <= 1'b0;
                    end else if (fl_req == `FFR_FLASH_NORMAL) begin
                        mode_transition_flag <= 1'b0;
                    end
                    // Wakeup racing entry keeps flash usable
                    if (lp_entry && wakeup) begin
                        flash_usable <= 1'b1;
                    end
                end
                ST_LOW: begin
                    if (fl_req == `FFR_FLASH_PD || fl_req == `FFR_FLASH_LP) begin
                        flash_sync_ok        <= 1'b1;
                        mode_transition_flag <= 1'b0;
                    end else if (fl_req == `FFR_FLASH_NORMAL && flash_sync_ok) begin
                        flash_state          <= ST_EXIT;
                        exit_cnt             <= EXIT_CYCLES;
                        mode_transition_flag <= 1'b1;
                    end else if (wakeup && flash_sync_ok) begin
                        flash_state <= ST_EXIT;
                        exit_cnt    <= EXIT_CYCLES;
                    end
                    // Unsynchronised wake leaves flash unusable
                    if (wakeup && !flash_sync_ok) begin
                        flash_usable <= 1'b0;
                    end
                end
                default: begin
                    if (exit_cnt <= 32'h0000_0001) begin
                        flash_state          <= ST_NORMAL;
                        flash_usable         <= 1'b1;
                        mode_transition_flag <= 1'b0;
                    end else begin
                        exit_cnt <= exit_cnt - 32'h0000_0001;
                    end
                end
            endcase
        end
    end
endmodule // ffr_core

//--- hdl/ffr_defs.vh
/*
 Shared constants for the flash fetch fault recovery block: register
 offsets, field positions, encodings, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FFR_DEFS_VH
`define FFR_DEFS_VH

// Register byte offsets on APB
`define FFR_OFF_MSR        12'h000
`define FFR_OFF_SYNDROME   12'h004
`define FFR_OFF_PREFIX     12'h008
`define FFR_OFF_MCVEC      12'h00c
`define FFR_OFF_MODE_CTL   12'h010
`define FFR_OFF_RUN0_CFG   12'h014
`define FFR_OFF_STATUS     12'h018
`define FFR_OFF_LP_CFG     12'h01c
`define FFR_OFF_HANDLER    12'h020
`define FFR_OFF_EVENT      12'h024

// Machine state register fields
`define FFR_MSR_ME_BIT     12
`define FFR_MSR_EE_BIT     15
`define FFR_MSR_ME_MASK    32'h0000_1000
`define FFR_MSR_RESET      32'h0000_0000

// Syndrome value for a read bus error on instruction fetch
`define FFR_SYN_FETCH_ERR  32'h0000_0010

// Fixed machine check vector offset
`define FFR_MC_OFFSET      12'h010

// Mode control keys
`define FFR_KEY            16'h5af0
`define FFR_KEY_INV        16'ha50f

// Run mode zero flash field, bits 17:16 of the config word
`define FFR_FLASH_LSB      16
`define FFR_FLASH_PD       2'b01
`define FFR_FLASH_LP       2'b10
`define FFR_FLASH_NORMAL   2'b11
`define FFR_RUN0_RESET     32'h001f_0010

// Flash exit time in ns and clock period in ns
`define FFR_EXIT_TIME_NS   1000
`define FFR_CLK_NS         4
`define FFR_EXIT_CYCLES    (`FFR_EXIT_TIME_NS / `FFR_CLK_NS)

`endif

//--- hdl/ffr_vec_mem.v
/*
 Small vector offset memory: one offset per interrupt type, registered
 read data. Assumes a single clock and synchronous writes.
*/
`timescale 1ns/1ps
module ffr_vec_mem #(
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock
    input  wire          pclk,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [11:0]   wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [11:0]   rd_data
);
    reg [11:0] mem [0:DEPTH-1];

    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // ffr_vec_mem

//--- test/ffr_core_checker.sv
/* Port checker for ffr_core.
   Assumes binding to every ffr_core instance, one clock. */
`timescale 1ns/1ps
module ffr_chk #(
    parameter HAS_CHECKSTOP = 1,
    parameter HAS_VEC_REGS  = 0,
    parameter EXIT_CYCLES   = 250
) (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    // Events and outcome
    input wire        fetch_req,
    input wire        irq_req,
    input wire [3:0]  irq_type,
    input wire        fetch_read_bus_error,
    input wire        checkstop_reset,
    input wire        mc_taken,
    input wire        irq_taken,
    input wire [31:0] handler_addr,
    input wire        flash_usable
);
    reg [31:0] pfx;
    reg [11:0] vec1;
    reg        pv;
    wire       wr = psel && penable && pwrite && pready;
    // Shadow only trusted once software wrote the prefix
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pfx  <= 32'h0000_0000;
            vec1 <= 12'h000;
            pv   <= 1'b0;
        end else begin
            if (wr && paddr == 12'h008) begin
                pfx <= pwdata;
                pv  <= 1'b1;
            end
            if (wr && paddr == 12'h044)
                vec1 <= pwdata[11:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cs; checkstop_reset ##1 !mc_taken; endsequence
    sequence s_mc; !checkstop_reset ##1 mc_taken; endsequence
    AST_FAULT_ERR: assert property (fetch_req && !flash_usable |=> fetch_read_bus_error)
        else $error("no bus error on unusable fetch");
    AST_ERR_CAUSE: assert property (fetch_read_bus_error |-> $past(fetch_req) && !$past(flash_usable))
        else $error("bus error without cause");
    AST_OUTCOME: assert property (fetch_read_bus_error |-> s_cs or s_mc)
        else $error("fault outcome wrong");
    AST_CS_CAUSE: assert property (checkstop_reset |-> fetch_read_bus_error)
        else $error("checkstop without fault");
    AST_NO_CS: assert property (!(HAS_CHECKSTOP == 0 && checkstop_reset))
        else $error("checkstop on variant without it");
    AST_MC_ADDR: assert property (mc_taken && pv && HAS_VEC_REGS == 0
        |-> handler_addr == {pfx[31:12], 12'h010})
        else $error("machine check address wrong");
    AST_VEC_ADDR: assert property (mc_taken && pv && HAS_VEC_REGS != 0
        |-> handler_addr == {pfx[31:12], vec1})
        else $error("vector register address wrong");
    AST_IRQ_LAT: assert property (irq_taken |-> $past(irq_req, 2))
        else $error("interrupt taken without request");
    AST_IRQ_ADDR: assert property (irq_taken && pv && HAS_VEC_REGS == 0
        |-> handler_addr == {pfx[31:12], 4'h0, $past(irq_type, 2), 4'h0})
        else $error("interrupt address wrong");
    AST_PREADY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule // ffr_chk

bind ffr_core ffr_chk #(.HAS_CHECKSTOP(HAS_CHECKSTOP), .HAS_VEC_REGS(HAS_VEC_REGS),
    .EXIT_CYCLES(EXIT_CYCLES)) ffr_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .fetch_req(fetch_req), .irq_req(irq_req), .irq_type(irq_type),
    .fetch_read_bus_error(fetch_read_bus_error), .checkstop_reset(checkstop_reset),
    .mc_taken(mc_taken), .irq_taken(irq_taken), .handler_addr(handler_addr),
    .flash_usable(flash_usable));

//--- test/ffr_evt_model.sv
/* Core and wakeup event source facing ffr_core.
   Assumes the same pclk; tasks are called from the bench. */
`timescale 1ns/1ps
module ffr_evt_model (
    // Clock
    input wire       pclk,
    // Events
    output reg       fetch_req,
    output reg       lp_entry,
    output reg       wakeup,
    output reg       irq_req,
    output reg [3:0] irq_type
);
    initial begin
        {irq_req, wakeup, lp_entry, fetch_req} = 4'h0;
        irq_type = 4'h0;
    end
    // One-cycle pulses; type flips after use so stale values are not trusted
    task pulse(input [3:0] ev, input [3:0] t);
        begin
            @(posedge pclk);
            {irq_req, wakeup, lp_entry, fetch_req} <= ev;
            irq_type <= t;
            @(posedge pclk);
            {irq_req, wakeup, lp_entry, fetch_req} <= 4'h0;
            irq_type <= ~t;
        end
    endtask
endmodule // ffr_evt_model

//--- test/tb_top.sv
/* Bench for ffr_core: APB master, event model, both core variants.
   Assumes the checker is bound to ffr_core. */
`timescale 1ns/1ps
module tb_top;
    localparam EXC = 8;
    reg         pclk, presetn, psel, penable, pwrite, er;
    reg  [11:0] paddr, vec;
    reg  [31:0] pwdata, rd, pfx;
    wire [31:0] prdata, ha, hb;
    wire        pready, pslverr, fr, lp, wk, iq, erra, csa, mca, ita, fua, errb, csb, mcb;
    wire [3:0]  it;
    integer     n_fail, check_count, cyc, i;

    ffr_core #(.EXIT_CYCLES(EXC)) ffr_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fetch_req(fr), .lp_entry(lp), .wakeup(wk),
        .irq_req(iq), .irq_type(it), .fetch_read_bus_error(erra), .checkstop_reset(csa),
        .mc_taken(mca), .irq_taken(ita), .handler_addr(ha), .flash_usable(fua));
    // Variant without checkstop, with offset registers
    ffr_core #(.HAS_CHECKSTOP(0), .HAS_VEC_REGS(1), .EXIT_CYCLES(EXC)) ffr_core_b_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .fetch_req(fr), .lp_entry(lp),
        .wakeup(wk), .irq_req(iq), .irq_type(it), .fetch_read_bus_error(errb),
        .checkstop_reset(csb), .mc_taken(mcb), .irq_taken(), .handler_addr(hb), .flash_usable());
    ffr_evt_model ffr_evt_model_i (.pclk(pclk), .fetch_req(fr), .lp_entry(lp), .wakeup(wk),
        .irq_req(iq), .irq_type(it));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task stop_test;
        begin
            if (n_fail == 0 && check_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // Whole test is well under a thousand cycles
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end

    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                $display("[FAIL] %0t got %h exp %h", $time, g, e);
                n_fail = n_fail + 1;
            end
        end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task mode(input [31:0] cfg);
        begin
            apb(1'b1, 12'h014, cfg);
            apb(1'b1, 12'h010, 32'h4000_5af0);
            apb(1'b1, 12'h010, 32'h4000_a50f);
        end
    endtask

    // Entry, late wakeup, then one fetch from flash
    task fault;
        begin
            ffr_evt_model_i.pulse(4'h2, 4'h0);
            repeat (3) @(posedge pclk);
            ffr_evt_model_i.pulse(4'h4, 4'h0);
            repeat (3) @(posedge pclk);
            #1 chk(fua, 0);
            ffr_evt_model_i.pulse(4'h1, 4'h0);
            #1 chk(erra, 1);
            chk(errb, 1);
        end
    endtask

    initial begin
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        {presetn, psel, penable, pwrite, er} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        i = $urandom(32'h049a);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h001f_0010);
        apb(1'b0, 12'h0fc, 32'h0);
        chk(er, 1);
        ffr_evt_model_i.pulse(4'h6, 4'h0);
        ffr_evt_model_i.pulse(4'h1, 4'h0);
        #1 chk(erra, 0);
        chk(fua, 1);
        fault;
        chk(csa, 1);
        chk(csb, 0);
        @(posedge pclk);
        #1 chk(mca, 0);
        chk(mcb, 1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd = $urandom;
        vec = rd[11:0];
        pfx = $urandom;
        apb(1'b1, 12'h044, {20'h0, vec});
        apb(1'b1, 12'h008, pfx);
        apb(1'b0, 12'h000, 32'h0);
        apb(1'b1, 12'h000, rd | 32'h0000_9000);
        for (i = 0; i < 16; i = i + 1) begin
            ffr_evt_model_i.pulse(4'h8, i[3:0]);
            @(posedge pclk);
            #1 chk(ita, 1);
            chk(ha, {pfx[31:12], 4'h0, i[3:0], 4'h0});
        end
        apb(1'b1, 12'h000, 32'h0000_9000);
        fault;
        chk(csa, 0);
        @(posedge pclk);
        #1 chk(mca, 1);
        chk(ha, {pfx[31:12], 12'h010});
        chk(hb, {pfx[31:12], vec});
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h0000_9000, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0010);
        apb(1'b1, 12'h004, 32'h0000_0010);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        // Broken key pair must leave the flash down
        apb(1'b1, 12'h014, 32'h001f_0010);
        apb(1'b1, 12'h010, 32'h4000_5af0);
        apb(1'b1, 12'h010, 32'h4000_1234);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd[0], 0);
        repeat (EXC + 4) @(posedge pclk);
        #1 chk(fua, 0);
        mode(32'h0015_0010);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd[0], 0);
        chk(fua, 0);
        mode(32'h001f_0010);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd[0], 1);
        repeat (EXC - 6) @(posedge pclk);
        #1 chk(fua, 0);
        i = 0;
        while (fua !== 1'b1 && i < 10) begin
            @(posedge pclk);
            #1 i = i + 1;
        end
        chk(fua, 1);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd[0], 0);
        ffr_evt_model_i.pulse(4'h1, 4'h0);
        #1 chk(erra, 0);
        fault;
        chk(csa, 1);
        @(posedge pclk);
        #1 chk(mcb, 1);
        stop_test;
    end
endmodule // tb_top
